// ===== logic/cbic_top.sv
// bus, interrupt and reset control for an 8-bit processor core
// assumes the core sits on mclk, presents each cycle during phase one
// and waits for core_advance before moving on
`timescale 1ns/1ps

// Contract
// - data pins driven only with enable high
// - read cycles never drive data pins
// - hold low in read freezes address
// - halt ends at phase two, hold high
// - hold ignored during write cycles
// - bus released flag high only when halted
// - maskable request taken at boundary, mask clear
// - sequence pushes pc and status
// - mask flag set after pushes
// - maskable vector FFFE then FFFF
// - no interrupt recognised while hold low
// - unmaskable falling edge requests sequence
// - unmaskable ignores mask flag
// - unmaskable vector FFFA then FFFB
// - maskable request sampled phase two, unmaskable edge every clock, start phase one
// - overflow input sets overflow flag
// - fetch marker high through opcode fetch
// - hold at fetch freezes processor
// - no writes while reset pin low
// - reset rising edge starts sequence
// - six init cycles, mask, vector FFFC/FFFD
module cbic_top (
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   // pins from the system
   input  wire logic        data_output_enable,
   input  wire logic        cycle_hold_input,
   input  wire logic        maskable_interrupt_request_n,
   input  wire logic        unmaskable_interrupt_request_n,
   input  wire logic        overflow_set_input,
   input  wire logic        reset_n,
   input  wire logic [7:0]  data_in,
   // pins to the system
   output logic      [15:0] addr_out,
   output logic      [7:0]  data_out,
   output logic             data_oe_n,
   output logic             rd_wr_n,
   output logic             bus_released_flag,
   output logic             opcode_fetch_marker,
   output logic             phase_two,
   // cycle request from the core
   input  wire logic [15:0] core_addr,
   input  wire logic [7:0]  core_wdata,
   input  wire logic        core_write,
   input  wire logic        core_fetch,
   input  wire logic        core_last,
   input  wire logic [15:0] core_pc,
   input  wire logic [7:0]  core_sp,
   input  wire logic [7:0]  core_p,
   input  wire logic        core_flag_wr,
   input  wire logic        core_flag_i,
   input  wire logic        core_flag_v,
   // answers to the core
   output logic             core_advance,
   output logic      [7:0]  core_rdata,
   output logic             pc_load,
   output logic      [15:0] pc_value,
   output logic             sp_load,
   output logic      [7:0]  sp_value,
   output logic             flag_i,
   output logic             flag_v
);
   import cbic_pkg::*;

   // ==========================================================
   // pin synchronisers
   logic [PIN_W-1:0] pin_f;
   logic dbe_f, rdy_f, irq_n_f, nmi_n_f, so_f, rst_f;

   cbic_sync u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .clk_en  (clk_en),
      .pin_raw ({reset_n, overflow_set_input, unmaskable_interrupt_request_n,
                 maskable_interrupt_request_n, cycle_hold_input,
                 data_output_enable}),
      .pin_f   (pin_f)
   );

   assign dbe_f   = pin_f[PIN_DBE];
   assign rdy_f   = pin_f[PIN_RDY];
   assign irq_n_f = pin_f[PIN_IRQN];
   assign nmi_n_f = pin_f[PIN_NMIN];
   assign so_f    = pin_f[PIN_SO];
   assign rst_f   = pin_f[PIN_RSTN];

   // ==========================================================
   // sequence generator
   cbic_seq_if sq ();
   cbic_seq    u_seq (.sq(sq.gen));

   // ==========================================================
   // state
   cbic_mode_e  mode_q, mode_d;
   cbic_kind_e  kind_q, kind_d;
   logic [3:0]  step_q, step_d;
   logic [7:0]  vlo_q, vlo_d;
   logic        rst_prev_q, rst_prev_d, nmi_prev_q, nmi_prev_d;
   logic        nmi_pend_q, nmi_pend_d, irq_q, irq_d;
   logic        i_q, i_d, v_q, v_d;
   logic        ph_q, ph_d, halt_q, halt_d;
   logic [15:0] addr_q, addr_d, pcv_q, pcv_d;
   logic [7:0]  wd_q, wd_d, rd_q, rd_d, spv_q, spv_d;
   logic        wr_q, wr_d, oe_n_q, oe_n_d, ba_q, ba_d, sync_q, sync_d;
   logic        adv_q, adv_d, pcl_q, pcl_d, spl_q, spl_d;
   logic        cyc_end, start_rst, nmi_fall, nmi_take, load, seq_done;

   assign sq.kind = kind_q;
   assign sq.step = step_q;
   assign sq.sp   = core_sp;
   assign sq.pc   = core_pc;
   // pushed status carries this block's mask (bit 2) and overflow (bit 6)
   assign sq.p    = {core_p[7], v_q, core_p[5:3], i_q, core_p[1:0]};

   // a cycle ends at phase two unless held; writes ignore the hold
   assign cyc_end   = ph_q & (rdy_f | wr_q) & (mode_q != CBIC_M_HOLD);
   assign start_rst = rst_f & ~rst_prev_q;
   assign nmi_fall  = nmi_prev_q & ~nmi_n_f;
   assign seq_done  = cyc_end & (mode_q == CBIC_M_SEQ) & sq.last;

   // ==========================================================
   // mode, sequence and flags: next values
   always_comb begin
      mode_d     = mode_q;
      kind_d     = kind_q;
      step_d     = step_q;
      vlo_d      = vlo_q;
      nmi_take   = 1'b0;
      rst_prev_d = rst_f;
      nmi_prev_d = nmi_n_f;
      irq_d      = ph_q ? ~irq_n_f : irq_q;
      i_d        = core_flag_wr ? core_flag_i : i_q;
      v_d        = core_flag_wr ? core_flag_v : v_q;
      if (!rst_f) begin
         mode_d = CBIC_M_HOLD;
      end else if (start_rst) begin
         mode_d = CBIC_M_SEQ;
         kind_d = CBIC_K_RST;
         step_d = 4'h0;
      end else if (cyc_end) begin
         unique case (mode_q)
            CBIC_M_RUN: begin
               // boundary only, and never while held
               if (core_last && rdy_f) begin
                  if (nmi_pend_q) begin
                     mode_d   = CBIC_M_SEQ;
                     kind_d   = CBIC_K_NMI;
                     step_d   = 4'h0;
                     nmi_take = 1'b1;
                  end else if (irq_q && !i_q) begin
                     mode_d = CBIC_M_SEQ;
                     kind_d = CBIC_K_IRQ;
                     step_d = 4'h0;
                  end
               end
            end
            CBIC_M_SEQ: begin
               step_d = step_q + STEP_ONE;
               if (sq.vec_lo) begin
                  vlo_d = data_in;
               end
               if (sq.last) begin
                  mode_d = CBIC_M_RUN;
               end
            end
            default: begin
               mode_d = mode_q;
            end
         endcase
      end
      // hardware sets win over a core write in the same cycle
      if (mode_q == CBIC_M_SEQ && sq.vec_lo) begin
         i_d = 1'b1;
      end
      if (so_f) begin
         v_d = 1'b1;
      end
      // a new edge beats the clear from the sequence start
      nmi_pend_d = nmi_fall | (nmi_pend_q & ~nmi_take);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_q     <= CBIC_M_HOLD;
         kind_q     <= CBIC_K_RST;
         step_q     <= 4'h0;
         vlo_q      <= 8'h00;
         rst_prev_q <= 1'b0;
         nmi_prev_q <= 1'b1;
         nmi_pend_q <= 1'b0;
         irq_q      <= 1'b0;
         i_q        <= RST_I_FLAG;
         v_q        <= RST_V_FLAG;
      end else if (clk_en) begin
         mode_q     <= mode_d;
         kind_q     <= kind_d;
         step_q     <= step_d;
         vlo_q      <= vlo_d;
         rst_prev_q <= rst_prev_d;
         nmi_prev_q <= nmi_prev_d;
         nmi_pend_q <= nmi_pend_d;
         irq_q      <= irq_d;
         i_q        <= i_d;
         v_q        <= v_d;
      end
   end

   // ==========================================================
   // phase, hold and bus outputs: next values
   always_comb begin
      // a fresh reset sequence always starts in phase one
      ph_d   = start_rst ? 1'b0 : ~ph_q;
      load   = ~ph_q & ~halt_q;
      addr_d = addr_q;
      wd_d   = wd_q;
      wr_d   = wr_q & rst_f;
      sync_d = sync_q;
      if (load) begin
         addr_d = (mode_q == CBIC_M_SEQ) ? sq.addr : core_addr;
         wd_d   = (mode_q == CBIC_M_SEQ) ? sq.wdata : core_wdata;
         wr_d   = rst_f & ((mode_q == CBIC_M_SEQ) ? sq.wr :
                           (mode_q == CBIC_M_RUN) & core_write);
         sync_d = rst_f & (mode_q == CBIC_M_RUN) & core_fetch;
      end
      // halted address stays put; covers the fetch cycle as well
      halt_d = (mode_q != CBIC_M_HOLD) & ~cyc_end & ~rdy_f & ~wr_d;
      ba_d   = halt_d;
      oe_n_d = ~(wr_d & dbe_f);
      rd_d   = cyc_end ? data_in : rd_q;
      adv_d  = cyc_end & (mode_q == CBIC_M_RUN) & rst_f & ~start_rst;
      pcl_d  = seq_done & rst_f & ~start_rst;
      pcv_d  = seq_done ? {data_in, vlo_q} : pcv_q;
      spl_d  = pcl_d & (kind_q != CBIC_K_RST);
      spv_d  = seq_done ? core_sp - SP_PUSHES : spv_q;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ph_q   <= 1'b0;
         halt_q <= 1'b0;
         addr_q <= RST_ADDR;
         wd_q   <= 8'h00;
         wr_q   <= 1'b0;
         oe_n_q <= 1'b1;
         ba_q   <= 1'b0;
         sync_q <= 1'b0;
         rd_q   <= 8'h00;
         adv_q  <= 1'b0;
         pcl_q  <= 1'b0;
         pcv_q  <= RST_ADDR;
         spl_q  <= 1'b0;
         spv_q  <= 8'h00;
      end else if (clk_en) begin
         ph_q   <= ph_d;
         halt_q <= halt_d;
         addr_q <= addr_d;
         wd_q   <= wd_d;
         wr_q   <= wr_d;
         oe_n_q <= oe_n_d;
         ba_q   <= ba_d;
         sync_q <= sync_d;
         rd_q   <= rd_d;
         adv_q  <= adv_d;
         pcl_q  <= pcl_d;
         pcv_q  <= pcv_d;
         spl_q  <= spl_d;
         spv_q  <= spv_d;
      end
   end

   // ==========================================================
   // outputs straight from flops
   assign addr_out            = addr_q;
   assign data_out            = wd_q;
   assign data_oe_n           = oe_n_q;
   assign rd_wr_n             = ~wr_q;
   assign bus_released_flag   = ba_q;
   assign opcode_fetch_marker = sync_q;
   assign phase_two           = ph_q;
   assign core_advance        = adv_q;
   assign core_rdata          = rd_q;
   assign pc_load             = pcl_q;
   assign pc_value            = pcv_q;
   assign sp_load             = spl_q;
   assign sp_value            = spv_q;
   assign flag_i              = i_q;
   assign flag_v              = v_q;

   // ==========================================================
   // checks
   a_read_no_drive: assert property (@(posedge mclk) disable iff (sys_rst)
      rd_wr_n |-> data_oe_n) else $error("data driven in read cycle");
   a_dbe_low_float: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && !dbe_f |=> data_oe_n) else $error("data driven with enable low");
   a_halt_addr_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      halt_q && clk_en |=> $stable(addr_out)) else $error("address moved while halted");
   a_released_not_write: assert property (@(posedge mclk) disable iff (sys_rst)
      bus_released_flag |-> rd_wr_n && $past(!rdy_f)) else $error("bus released badly");
   a_reset_no_write: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && !rst_f |=> rd_wr_n) else $error("write during reset");
   a_reset_vector_time: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(rst_f) && clk_en && rdy_f ##1 (clk_en && rdy_f)[*8]
      |-> ##[4:6] addr_out == VEC_RST_LO) else $error("reset vector late");
   a_nmi_edge_latch: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && nmi_fall |=> nmi_pend_q) else $error("nmi edge lost");
   a_irq_mask_gate: assert property (@(posedge mclk) disable iff (sys_rst)
      mode_q == CBIC_M_RUN && mode_d == CBIC_M_SEQ && kind_d == CBIC_K_IRQ |-> !i_q)
      else $error("masked request taken");
   a_mask_after_push: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && mode_q == CBIC_M_SEQ && sq.vec_lo |=> flag_i) else $error("mask not set");
   a_overflow_set: assert property (@(posedge mclk) disable iff (sys_rst)
      clk_en && so_f |=> flag_v) else $error("overflow not set");
   a_fetch_is_read: assert property (@(posedge mclk) disable iff (sys_rst)
      opcode_fetch_marker |-> rd_wr_n && ($stable(opcode_fetch_marker) || phase_two))
      else $error("fetch marker in write");
endmodule

// ===== shared/cbic_pkg.sv
// constants and types shared by the bus, interrupt and reset control
// assumes a single 25 MHz clock; one machine cycle is two clocks
package cbic_pkg;

   // ==========================================================
   // clocking
   localparam int unsigned CLK_HZ      = 25_000_000;
   localparam int unsigned CLK_PER_CYC = 2;

   // ==========================================================
   // vectors and stack
   localparam logic [15:0] VEC_NMI_LO  = 16'hFFFA;
   localparam logic [15:0] VEC_RST_LO  = 16'hFFFC;
   localparam logic [15:0] VEC_IRQ_LO  = 16'hFFFE;
   localparam logic [15:0] VEC_HI_OFS  = 16'h0001;
   localparam logic [7:0]  STACK_PAGE  = 8'h01;
   localparam logic [7:0]  SP_PUSHES   = 8'h03;

   // ==========================================================
   // sequence step counts
   localparam logic [3:0]  RST_INIT_CYC = 4'h6;
   localparam logic [3:0]  PUSH_CYC     = 4'h3;
   localparam logic [3:0]  STEP_ONE     = 4'h1;

   // ==========================================================
   // synchronised pin vector: field positions and reset value
   localparam int unsigned PIN_W    = 6;
   localparam int unsigned PIN_DBE  = 0;
   localparam int unsigned PIN_RDY  = 1;
   localparam int unsigned PIN_IRQN = 2;
   localparam int unsigned PIN_NMIN = 3;
   localparam int unsigned PIN_SO   = 4;
   localparam int unsigned PIN_RSTN = 5;
   localparam logic [PIN_W-1:0] PIN_RST_VAL = 6'h0E;

   // ==========================================================
   // reset values of control state
   localparam logic        RST_I_FLAG = 1'b1;
   localparam logic        RST_V_FLAG = 1'b0;
   localparam logic [15:0] RST_ADDR   = 16'h0000;

   typedef enum logic [1:0] {CBIC_K_RST, CBIC_K_IRQ, CBIC_K_NMI} cbic_kind_e;
   typedef enum logic [1:0] {CBIC_M_HOLD, CBIC_M_RUN, CBIC_M_SEQ} cbic_mode_e;

endpackage

// ===== shared/cbic_seq_if.sv
// interface between the control top and the sequence cycle generator
// assumes both ends sit in the mclk domain
`timescale 1ns/1ps
interface cbic_seq_if;
   import cbic_pkg::*;
   cbic_kind_e  kind;
   logic [3:0]  step;
   logic [7:0]  sp;
   logic [15:0] pc;
   logic [7:0]  p;
   logic [15:0] addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        vec_lo;
   logic        last;
   modport ctl (output kind, step, sp, pc, p, input addr, wdata, wr, vec_lo, last);
   modport gen (input kind, step, sp, pc, p, output addr, wdata, wr, vec_lo, last);
endinterface

// ===== logic/cbic_sync.sv
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to mclk
`timescale 1ns/1ps
module cbic_sync (
   // clock and control
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic                      clk_en,
   // pins in, filtered levels out
   input  wire logic [cbic_pkg::PIN_W-1:0] pin_raw,
   output logic      [cbic_pkg::PIN_W-1:0] pin_f
);
   import cbic_pkg::*;

   logic [PIN_W-1:0] s1_q, s2_q, s3_q, f_q, f_d;

   // ==========================================================
   // filter: a change counts once stages two and three agree
   always_comb begin
      f_d = f_q;
      for (int i = 0; i < PIN_W; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            f_d[i] = s3_q[i];
         end
      end
   end

   // first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s1_q <= PIN_RST_VAL;
         s2_q <= PIN_RST_VAL;
         s3_q <= PIN_RST_VAL;
         f_q  <= PIN_RST_VAL;
      end else if (clk_en) begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         f_q  <= f_d;
      end
   end

   assign pin_f = f_q;
endmodule

// ===== logic/cbic_seq.sv
// cycle generator for reset and interrupt sequences
// assumes the caller steps it once per completed machine cycle
`timescale 1ns/1ps
module cbic_seq (
   // sequence request and generated cycle
   cbic_seq_if.gen sq
);
   import cbic_pkg::*;

   logic [3:0] vstep;

   // ==========================================================
   // vector base per kind; illegal kind code falls to nmi
   function automatic logic [15:0] vec_base(input cbic_kind_e k);
      unique case (k)
         CBIC_K_RST: vec_base = VEC_RST_LO;
         CBIC_K_IRQ: vec_base = VEC_IRQ_LO;
         default:    vec_base = VEC_NMI_LO;
      endcase
   endfunction

   // pushes (or idle init cycles) first, then vector low, then high
   always_comb begin
      vstep     = (sq.kind == CBIC_K_RST) ? RST_INIT_CYC : PUSH_CYC;
      sq.addr   = {STACK_PAGE, sq.sp};
      sq.wdata  = 8'h00;
      sq.wr     = 1'b0;
      sq.vec_lo = 1'b0;
      sq.last   = 1'b0;
      if (sq.step < vstep) begin
         // reset init cycles are reads: no stack damage
         if (sq.kind != CBIC_K_RST) begin
            sq.wr   = 1'b1;
            sq.addr = {STACK_PAGE, sq.sp - {4'h0, sq.step}};
            unique case (sq.step)
               4'h0:    sq.wdata = sq.pc[15:8];
               4'h1:    sq.wdata = sq.pc[7:0];
               default: sq.wdata = sq.p;
            endcase
         end
      end else if (sq.step == vstep) begin
         sq.addr   = vec_base(sq.kind);
         sq.vec_lo = 1'b1;
      end else begin
         sq.addr = vec_base(sq.kind) + VEC_HI_OFS;
         sq.last = 1'b1;
      end
   end
endmodule

// ===== tb/cbic_mem_model.sv
// memory and glue logic model for the far side of the control block
// assumes one mclk domain; the hold pin doubles as the slow-memory wait
`timescale 1ns/1ps
module cbic_mem_model (
   // clock
   input  wire logic        mclk,
   // bus from the block
   input  wire logic [15:0] addr_out,
   input  wire logic        rd_wr_n,
   input  wire logic        phase_two,
   input  wire logic        cycle_hold_input,
   // test control
   input  wire logic        oe_off,
   // answers to the block
   output logic             data_output_enable,
   output logic      [7:0]  data_in
);
   // ==========================================================
   // memory contents
   // content is a fixed function of the address, so reads need no storage
   function automatic logic [7:0] mem_byte(input logic [15:0] a);
      return a[7:0] ^ {a[14:8], a[15]} ^ 8'h5A;
   endfunction

   // ==========================================================
   // bus answers
   logic [7:0] last_q = 8'hA5;
   // enable held as a level: a clock-rate enable never settles in the pin filter
   assign data_output_enable = ~oe_off;
   // data valid in phase two once the wait is over; else the inverse of the last value
   assign data_in = (rd_wr_n && cycle_hold_input && phase_two) ? mem_byte(addr_out) : ~last_q;
   // remembers the bus so the idle pattern keeps changing
   always_ff @(posedge mclk) begin
      last_q <= data_in;
   end
endmodule

// ===== tb/cbic_top_tb.sv
// self-checking bench for the bus, interrupt and reset control block
// assumes the memory model answers reads; core requests come from tasks
`timescale 1ns/1ps
module cbic_top_tb;
   import cbic_pkg::*;
   // ==========================================================
   // signals
   logic        mclk, sys_rst, clk_en, data_output_enable, cycle_hold_input;
   logic        maskable_interrupt_request_n, unmaskable_interrupt_request_n;
   logic        overflow_set_input, reset_n, data_oe_n, rd_wr_n, bus_released_flag;
   logic        opcode_fetch_marker, phase_two, core_write, core_fetch, core_last;
   logic        core_flag_wr, core_flag_i, core_flag_v, core_advance, pc_load, sp_load;
   logic        flag_i, flag_v, oe_off;
   logic [7:0]  data_in, data_out, core_wdata, core_sp, core_p, core_rdata, sp_value;
   logic [15:0] addr_out, core_addr, core_pc, pc_value;
   logic [15:0] exp_pc[$];
   logic [8:0]  exp_rd[$];
   logic [23:0] exp_wr[$];
   logic [7:0]  exp_sp[$];
   logic [31:0] r;
   int          n_mismatch, total_checks, oe_low, cyc, k;

   // ==========================================================
   // design and far side
   cbic_top DUT (.mclk, .sys_rst, .clk_en, .data_output_enable, .cycle_hold_input,
      .maskable_interrupt_request_n, .unmaskable_interrupt_request_n, .overflow_set_input,
      .reset_n, .data_in, .addr_out, .data_out, .data_oe_n, .rd_wr_n, .bus_released_flag,
      .opcode_fetch_marker, .phase_two, .core_addr, .core_wdata, .core_write, .core_fetch,
      .core_last, .core_pc, .core_sp, .core_p, .core_flag_wr, .core_flag_i, .core_flag_v,
      .core_advance, .core_rdata, .pc_load, .pc_value, .sp_load, .sp_value, .flag_i, .flag_v);
   cbic_mem_model u_mem (.mclk, .addr_out, .rd_wr_n, .phase_two, .cycle_hold_input,
      .oe_off, .data_output_enable, .data_in);

   always #20 mclk = ~mclk;

   // ==========================================================
   // compare and close
   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      chk({23'h0, got}, {23'h0, exp}, what);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // ==========================================================
   // result watcher: each result takes the oldest note of its kind
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         summarize();
      end
      if (!sys_rst) begin
         if (pc_load && exp_pc.size() == 0) chk1(1'b1, 1'b0, "unexpected pc load");
         else if (pc_load) chk({8'h0, pc_value}, {8'h0, exp_pc.pop_front()}, "vector");
         if (sp_load && exp_sp.size() == 0) chk1(1'b1, 1'b0, "unexpected sp load");
         else if (sp_load) chk({16'h0, sp_value}, {16'h0, exp_sp.pop_front()}, "sp");
         if (core_advance && exp_rd.size() == 0) chk1(1'b1, 1'b0, "extra advance");
         else if (core_advance && exp_rd[0][8]) chk({16'h0, core_rdata},
            {16'h0, 8'(exp_rd.pop_front())}, "rdata") ;
         else if (core_advance) exp_rd.pop_front();
         if (phase_two && !rd_wr_n && exp_wr.size() == 0) chk1(1'b1, 1'b0, "extra write");
         else if (phase_two && !rd_wr_n) chk({addr_out, data_out}, exp_wr.pop_front(), "write");
         if (!reset_n && !rd_wr_n) chk1(rd_wr_n, 1'b1, "write in reset");
         if (bus_released_flag && !rd_wr_n) chk1(1'b1, 1'b0, "released in write");
         if (!data_oe_n) chk1(rd_wr_n, 1'b0, "drive in read");
         if (!data_oe_n) oe_low++;
      end
   end

   // ==========================================================
   // core cycle driver; the core request stays put until advance
   task automatic core_cyc(input logic [15:0] a, input logic [7:0] d, input logic wr,
                           input logic fetch, input logic last, input int hold, input bit mark);
      int n;
      core_addr  = a;
      core_wdata = d;
      core_write = wr;
      core_fetch = fetch;
      core_last  = last;
      exp_rd.push_back({~wr, u_mem.mem_byte(a)});
      if (wr) exp_wr.push_back({a, d});
      n = 0;
      do begin
         @(posedge mclk);
         #1;
         n++;
         core_flag_wr = 1'b0;
         if (mark && n == 1) chk1(opcode_fetch_marker, fetch, "fetch marker");
         if (n == hold) begin
            chk1(bus_released_flag, 1'b1, "released");
            chk({8'h0, addr_out}, {8'h0, a}, "held address");
            chk1(core_advance, 1'b0, "advance in hold");
            cycle_hold_input = 1'b1;
         end
      end while (!core_advance && n < 400);
      chk1(core_advance, 1'b1, "advance");
   endtask

   // pushes, then the vector pair; mask and overflow bits come from the block
   task automatic expect_seq(input logic [15:0] vec, input logic i_now, input logic v_now);
      exp_wr.push_back({STACK_PAGE, core_sp, core_pc[15:8]});
      exp_wr.push_back({STACK_PAGE, core_sp - 8'h01, core_pc[7:0]});
      exp_wr.push_back({STACK_PAGE, core_sp - 8'h02, core_p[7], v_now, core_p[5:3], i_now,
                        core_p[1:0]});
      exp_pc.push_back({u_mem.mem_byte(vec + VEC_HI_OFS), u_mem.mem_byte(vec)});
      exp_sp.push_back(core_sp - SP_PUSHES);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      {mclk, clk_en, sys_rst, cycle_hold_input} = 4'hF;
      {maskable_interrupt_request_n, unmaskable_interrupt_request_n} = 2'h3;
      {overflow_set_input, reset_n, oe_off, core_flag_wr, core_flag_i, core_flag_v} = 6'h0;
      {core_write, core_fetch, core_last, core_addr, core_wdata} = 27'h0;
      r = $urandom(32'h2bb6);
      core_pc = 16'($urandom);
      core_sp = 8'($urandom);
      core_p  = 8'($urandom);
      repeat (4) @(posedge mclk);
      #1 sys_rst = 1'b0;
      // reset pin held low for several machine cycles
      repeat (8) @(posedge mclk);
      exp_pc.push_back({u_mem.mem_byte(VEC_RST_LO + VEC_HI_OFS), u_mem.mem_byte(VEC_RST_LO)});
      #1 reset_n = 1'b1;
      core_cyc(16'h0200, 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      chk1(flag_i, 1'b1, "mask after reset");
      // random reads, writes and fetches back to back
      for (k = 0; k < 12; k++) begin
         r = $urandom;
         core_cyc(r[15:0], r[23:16], r[24], r[25] & ~r[24], 1'b0, 0, 1);
      end
      // hold low: writes complete (the last one sees the synced hold), the read halts
      cycle_hold_input = 1'b0;
      for (k = 0; k < 3; k++) core_cyc(16'h0300 + 16'(k), 8'h3C, 1'b1, 1'b0, 1'b0, 0, 0);
      core_cyc(16'h0301, 8'h00, 1'b0, 1'b0, 1'b0, 12, 0);
      // flags cleared by the core, then overflow set from the pin
      {core_flag_wr, core_flag_i, core_flag_v} = 3'b100;
      core_cyc(16'h0400, 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      overflow_set_input = 1'b1;
      for (k = 0; k < 4; k++) core_cyc(16'h0401 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      overflow_set_input = 1'b0;
      chk1(flag_v, 1'b1, "overflow set");
      // maskable request taken at an instruction end with the mask clear
      maskable_interrupt_request_n = 1'b0;
      for (k = 0; k < 3; k++) core_cyc(16'h0500 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      expect_seq(VEC_IRQ_LO, 1'b0, 1'b1);
      core_cyc(16'h0510, 8'h00, 1'b0, 1'b0, 1'b1, 0, 0);
      maskable_interrupt_request_n = 1'b1;
      core_cyc(16'h0511, 8'h00, 1'b0, 1'b1, 1'b0, 0, 0);
      chk1(flag_i, 1'b1, "mask after entry");
      // mask set: request ignored at several instruction ends
      maskable_interrupt_request_n = 1'b0;
      for (k = 0; k < 3; k++) core_cyc(16'h0600 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b1, 0, 0);
      maskable_interrupt_request_n = 1'b1;
      for (k = 0; k < 3; k++) core_cyc(16'h0610 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      // short unmaskable pulse, long before the instruction ends
      unmaskable_interrupt_request_n = 1'b0;
      for (k = 0; k < 2; k++) core_cyc(16'h0700 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      unmaskable_interrupt_request_n = 1'b1;
      for (k = 0; k < 2; k++) core_cyc(16'h0710 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      expect_seq(VEC_NMI_LO, 1'b1, 1'b1);
      core_cyc(16'h0720, 8'h00, 1'b0, 1'b0, 1'b1, 0, 0);
      core_cyc(16'h0721, 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      // data pins stay undriven while the enable is held low
      oe_off = 1'b1;
      for (k = 0; k < 3; k++) core_cyc(16'h0800 + 16'(k), 8'h00, 1'b0, 1'b0, 1'b0, 0, 0);
      r = oe_low;
      for (k = 0; k < 3; k++) core_cyc(16'h0810 + 16'(k), 8'(k), 1'b1, 1'b0, 1'b0, 0, 0);
      chk(24'(oe_low), r[23:0], "driven while disabled");
      oe_off = 1'b0;
      for (k = 0; k < 4; k++) core_cyc(16'h0820 + 16'(k), 8'(k), 1'b1, 1'b0, 1'b0, 0, 0);
      chk1(oe_low > r, 1'b1, "drive with enable");
      chk(24'(exp_wr.size() + exp_pc.size() + exp_sp.size()), 24'h0, "pending results");
      summarize();
   end
endmodule
